// [pkg/csf_pkg.sv]
// csf_pkg: constants and carrier types of the core datapath
package csf_pkg;
  localparam int NREG = 32;
  localparam int IRQ_N = 8;
  localparam int IRQ_IDW = 3;
  // data space windows
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_LAST = 16'h005F;
  localparam logic [15:0] EXT_FIRST = 16'h0060;
  localparam logic [15:0] EXT_LAST = 16'h01FF;
  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // pointer pair low registers
  localparam logic [4:0] PTR_X = 5'h1A;
  localparam logic [4:0] PTR_Y = 5'h1C;
  localparam logic [4:0] PTR_Z = 5'h1E;
  // major opcodes, instruction bits 15:12
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_ARITH = 4'h1;
  localparam logic [3:0] OP_LOGIC = 4'h2;
  localparam logic [3:0] OP_LDI = 4'h3;
  localparam logic [3:0] OP_SUBI = 4'h4;
  localparam logic [3:0] OP_BITCP = 4'h5;
  localparam logic [3:0] OP_LDST = 4'h6;
  localparam logic [3:0] OP_IO = 4'h7;
  localparam logic [3:0] OP_RJMP = 4'h8;
  localparam logic [3:0] OP_RCALL = 4'h9;
  localparam logic [3:0] OP_BRANCH = 4'hA;
  localparam logic [3:0] OP_JMP = 4'hB;
  localparam logic [3:0] OP_PMEM = 4'hC;
  localparam logic [3:0] OP_UNARY = 4'hD;
  // misc sub-ops, bits 3:0
  localparam logic [3:0] MS_GIE_SET = 4'h1;
  localparam logic [3:0] MS_GIE_CLR = 4'h2;
  localparam logic [3:0] MS_RET_INT = 4'h3;
  localparam logic [3:0] MS_RET = 4'h4;
  // unary sub-ops, bits 2:0
  localparam logic [2:0] UN_COM = 3'h0;
  localparam logic [2:0] UN_NEG = 3'h1;
  localparam logic [2:0] UN_INC = 3'h2;
  localparam logic [2:0] UN_DEC = 3'h3;
  localparam logic [2:0] UN_LSR = 3'h4;
  localparam logic [7:0] INC_OVF = 8'h80;
  localparam logic [7:0] DEC_OVF = 8'h7F;
  // apb register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_SP = 8'h0C;
  localparam logic RUN_RESET = 1'b1;

  typedef enum logic [2:0] {
    PH_RUN = 3'b000,
    PH_PUSH = 3'b001,
    PH_RDWAIT = 3'b010,
    PH_RDTAKE = 3'b011,
    PH_JMP2 = 3'b100,
    PH_LPM1 = 3'b101,
    PH_LPM2 = 3'b110
  } csf_phase_t;

  typedef enum logic [1:0] {
    RDP_REG = 2'b00,
    RDP_PCHI = 2'b01,
    RDP_PCLO = 2'b10
  } csf_rdp_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic io;
    logic ext;
  } csf_dm_t;

  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } csf_pmw_t;

  typedef struct packed {
    csf_phase_t ph;
    csf_rdp_t rdp;
    logic run;
    logic v;
    logic [15:0] pc;
    logic [15:0] tmp;
    logic [15:0] sp;
    logic [7:0] rhi;
    logic [7:0] flags;
    logic [4:0] dst;
    logic [NREG-1:0][7:0] rf;
    csf_dm_t dm;
    csf_pmw_t pmw;
    logic ack;
    logic [IRQ_IDW-1:0] ack_id;
    logic [31:0] prdata;
  } csf_core_t;
endpackage

// [rtl/csf_core.sv]
// csf_core: 8-bit core datapath with status flags and apb debug port
//
// The APB register port and the register addresses were left to the implementer.
module csf_core import csf_pkg::*; #(
  parameter logic [15:0] SP_INIT = 16'h21FF,
  parameter logic [15:0] BOOT_START = 16'hF000,
  parameter logic [15:0] VEC_BASE = 16'h0002,
  parameter logic [15:0] VEC_STRIDE = 16'h0002
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program memory, synchronous read
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  output csf_pmw_t pm_wr,
  // data memory and i/o, synchronous read
  output csf_dm_t dm_req,
  input wire logic [7:0] dm_rdata,
  // interrupt requests, already individually enabled
  input wire logic [IRQ_N-1:0] irq,
  output logic irq_ack,
  output logic [IRQ_IDW-1:0] irq_ack_id
);
  csf_core_t s_q, s_d;
  logic [15:0] ir, ea, ptr, zp, ioa;
  logic [4:0] rd_i, rr_i, rdh, plo;
  logic [7:0] a, b, aa, bb, res, f;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic sub, cin, wr, arv, pop;
  logic [4:0] wdst;
  logic [IRQ_IDW-1:0] idx;
  logic apb_wr, mapped;

  always_comb begin
    s_d = s_q;
    s_d.dm.we = 1'b0;
    s_d.dm.re = 1'b0;
    s_d.pmw.we = 1'b0;
    s_d.ack = 1'b0;
    ir = pm_rdata;
    ea = s_q.pc - 16'h0001;
    rd_i = ir[11:7];
    rr_i = ir[6:2];
    rdh = {1'b1, ir[11:8]};
    plo = (ir[1:0] == 2'b00) ? PTR_X : (ir[1:0] == 2'b01) ? PTR_Y : PTR_Z;
    ptr = {s_q.rf[plo + 5'h01], s_q.rf[plo]};
    zp = {s_q.rf[PTR_Z + 5'h01], s_q.rf[PTR_Z]};
    // direct i/o maps after the registers
    ioa = IO_BASE + {10'h000, ir[5:0]};
    a = s_q.rf[rd_i];
    b = s_q.rf[rr_i];
    aa = (ir[15:12] == OP_SUBI) ? s_q.rf[rdh] : a;
    bb = (ir[15:12] == OP_SUBI) ? ir[7:0] : b;
    sub = (ir[15:12] == OP_SUBI) | ir[1];
    cin = (ir[15:12] == OP_ARITH) & ir[0] & s_q.flags[FLAG_C];
    if (sub) begin
      sum9 = {1'b0, aa} - {1'b0, bb} - {8'h00, cin};
      sum5 = {1'b0, aa[3:0]} - {1'b0, bb[3:0]} - {4'h0, cin};
      arv = (aa[7] & ~bb[7] & ~sum9[7]) | (~aa[7] & bb[7] & sum9[7]);
    end else begin
      sum9 = {1'b0, aa} + {1'b0, bb} + {8'h00, cin};
      sum5 = {1'b0, aa[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      arv = (aa[7] & bb[7] & ~sum9[7]) | (~aa[7] & ~bb[7] & sum9[7]);
    end
    idx = '0;
    for (int k = IRQ_N - 1; k >= 0; k--) begin
      if (irq[k]) begin
        idx = IRQ_IDW'(k);
      end
    end
    f = s_q.flags;
    res = 8'h00;
    wr = 1'b0;
    wdst = rd_i;
    pop = 1'b0;
    case (s_q.ph)
      PH_RUN: begin
        if (!s_q.run) begin
          s_d.v = 1'b0;
        end else if (!s_q.v) begin
          s_d.pc = s_q.pc + 16'h0001;
          s_d.v = 1'b1;
        end else if (s_q.flags[FLAG_I] && |irq) begin
          f[FLAG_I] = 1'b0;
          s_d.ack = 1'b1;
          s_d.ack_id = idx;
          s_d.dm.we = 1'b1;
          s_d.dm.addr = s_q.sp;
          s_d.dm.wdata = ea[7:0];
          s_d.rhi = ea[15:8];
          s_d.sp = s_q.sp - 16'h0001;
          s_d.tmp = VEC_BASE + VEC_STRIDE * {{(16-IRQ_IDW){1'b0}}, idx};
          s_d.v = 1'b0;
          s_d.ph = PH_PUSH;
        end else begin
          s_d.pc = s_q.pc + 16'h0001;
          s_d.v = 1'b1;
          case (ir[15:12])
            OP_MISC: begin
              case (ir[3:0])
                MS_GIE_SET: f[FLAG_I] = 1'b1;
                MS_GIE_CLR: f[FLAG_I] = 1'b0;
                MS_RET_INT: begin
                  f[FLAG_I] = 1'b1;
                  pop = 1'b1;
                end
                MS_RET: pop = 1'b1;
                default: ;
              endcase
            end
            OP_ARITH, OP_SUBI: begin
              wr = 1'b1;
              wdst = (ir[15:12] == OP_SUBI) ? rdh : rd_i;
              res = sum9[7:0];
              f[FLAG_C] = sum9[8];
              f[FLAG_H] = sum5[4];
              f[FLAG_V] = arv;
              f[FLAG_N] = sum9[7];
              f[FLAG_Z] = (sum9[7:0] == 8'h00);
            end
            OP_LOGIC: begin
              wr = 1'b1;
              case (ir[1:0])
                2'b00: res = a & b;
                2'b01: res = a | b;
                2'b10: res = a ^ b;
                default: res = b;
              endcase
              if (ir[1:0] != 2'b11) begin
                f[FLAG_V] = 1'b0;
                f[FLAG_N] = res[7];
                f[FLAG_Z] = (res == 8'h00);
              end
            end
            OP_LDI: begin
              wr = 1'b1;
              wdst = rdh;
              res = ir[7:0];
            end
            OP_BITCP: begin
              // copy bit to or from flag
              if (!ir[3]) begin
                f[FLAG_T] = a[ir[2:0]];
              end else begin
                wr = 1'b1;
                res = a;
                res[ir[2:0]] = s_q.flags[FLAG_T];
              end
            end
            OP_LDST: begin
              if (ptr < IO_BASE) begin
                wr = 1'b1;
                wdst = ir[2] ? ptr[4:0] : rd_i;
                res = ir[2] ? a : s_q.rf[ptr[4:0]];
              end else if (ir[2]) begin
                s_d.dm.we = 1'b1;
                s_d.dm.addr = ptr;
                s_d.dm.wdata = a;
              end else begin
                s_d.dm.re = 1'b1;
                s_d.dm.addr = ptr;
                s_d.rdp = RDP_REG;
                s_d.dst = rd_i;
                s_d.pc = s_q.pc;
                s_d.v = 1'b0;
                s_d.ph = PH_RDWAIT;
              end
            end
            OP_IO: begin
              s_d.dm.addr = ioa;
              if (ir[6]) begin
                s_d.dm.we = 1'b1;
                s_d.dm.wdata = a;
              end else begin
                s_d.dm.re = 1'b1;
                s_d.rdp = RDP_REG;
                s_d.dst = rd_i;
                s_d.pc = s_q.pc;
                s_d.v = 1'b0;
                s_d.ph = PH_RDWAIT;
              end
            end
            OP_RJMP: begin
              s_d.pc = s_q.pc + {{4{ir[11]}}, ir[11:0]};
              s_d.v = 1'b0;
            end
            OP_RCALL: begin
              s_d.dm.we = 1'b1;
              s_d.dm.addr = s_q.sp;
              s_d.dm.wdata = s_q.pc[7:0];
              s_d.rhi = s_q.pc[15:8];
              s_d.sp = s_q.sp - 16'h0001;
              s_d.tmp = s_q.pc + {{4{ir[11]}}, ir[11:0]};
              s_d.v = 1'b0;
              s_d.ph = PH_PUSH;
            end
            OP_BRANCH: begin
              if (s_q.flags[ir[11:9]] == ir[8]) begin
                s_d.pc = s_q.pc + {{8{ir[7]}}, ir[7:0]};
                s_d.v = 1'b0;
              end
            end
            OP_JMP: begin
              s_d.v = 1'b0;
              s_d.ph = PH_JMP2;
            end
            OP_PMEM: begin
              if (!ir[0]) begin
                s_d.tmp = s_q.pc;
                s_d.pc = {1'b0, zp[15:1]};
                s_d.rhi = {7'h00, zp[0]};
                s_d.dst = rd_i;
                s_d.v = 1'b0;
                s_d.ph = PH_LPM1;
              end else if (ea >= BOOT_START) begin
                s_d.pmw.we = 1'b1;
                s_d.pmw.addr = {1'b0, zp[15:1]};
                s_d.pmw.wdata = {s_q.rf[1], s_q.rf[0]};
              end
            end
            OP_UNARY: begin
              wr = 1'b1;
              case (ir[2:0])
                UN_COM: begin
                  res = ~a;
                  f[FLAG_C] = 1'b1;
                  f[FLAG_V] = 1'b0;
                end
                UN_NEG: begin
                  res = 8'h00 - a;
                  f[FLAG_C] = (a != 8'h00);
                  f[FLAG_V] = (res == INC_OVF);
                  f[FLAG_H] = res[3] | a[3];
                end
                UN_INC: begin
                  res = a + 8'h01;
                  f[FLAG_V] = (res == INC_OVF);
                end
                UN_DEC: begin
                  res = a - 8'h01;
                  f[FLAG_V] = (res == DEC_OVF);
                end
                default: begin
                  res = {1'b0, a[7:1]};
                  f[FLAG_C] = a[0];
                  f[FLAG_V] = a[0];
                end
              endcase
              f[FLAG_N] = res[7];
              f[FLAG_Z] = (res == 8'h00);
            end
            default: ;
          endcase
          if (pop) begin
            s_d.dm.re = 1'b1;
            s_d.dm.addr = s_q.sp + 16'h0001;
            s_d.rdp = RDP_PCHI;
            s_d.pc = s_q.pc;
            s_d.v = 1'b0;
            s_d.ph = PH_RDWAIT;
          end
        end
      end
      PH_PUSH: begin
        s_d.dm.we = 1'b1;
        s_d.dm.addr = s_q.sp;
        s_d.dm.wdata = s_q.rhi;
        s_d.sp = s_q.sp - 16'h0001;
        s_d.pc = s_q.tmp;
        s_d.ph = PH_RUN;
      end
      PH_RDWAIT: s_d.ph = PH_RDTAKE;
      PH_RDTAKE: begin
        case (s_q.rdp)
          RDP_PCHI: begin
            s_d.rhi = dm_rdata;
            s_d.dm.re = 1'b1;
            s_d.dm.addr = s_q.sp + 16'h0002;
            s_d.rdp = RDP_PCLO;
            s_d.ph = PH_RDWAIT;
          end
          RDP_PCLO: begin
            s_d.pc = {s_q.rhi, dm_rdata};
            s_d.sp = s_q.sp + 16'h0002;
            s_d.ph = PH_RUN;
          end
          default: begin
            wr = 1'b1;
            wdst = s_q.dst;
            res = dm_rdata;
            s_d.pc = s_q.pc + 16'h0001;
            s_d.v = 1'b1;
            s_d.ph = PH_RUN;
          end
        endcase
      end
      PH_JMP2: begin
        s_d.pc = ir;
        s_d.ph = PH_RUN;
      end
      PH_LPM1: begin
        s_d.pc = s_q.tmp;
        s_d.ph = PH_LPM2;
      end
      PH_LPM2: begin
        wr = 1'b1;
        wdst = s_q.dst;
        res = s_q.rhi[0] ? ir[15:8] : ir[7:0];
        s_d.pc = s_q.pc + 16'h0001;
        s_d.v = 1'b1;
        s_d.ph = PH_RUN;
      end
      default: s_d.ph = PH_RUN;
    endcase
    if (wr) begin
      s_d.rf[wdst] = res;
    end
    // tag window for the decoders outside
    s_d.dm.io = (s_d.dm.addr >= IO_BASE) && (s_d.dm.addr <= IO_LAST);
    s_d.dm.ext = (s_d.dm.addr >= EXT_FIRST) && (s_d.dm.addr <= EXT_LAST);
    // apb: reads latched in setup, writes at access
    apb_wr = psel & penable & pwrite;
    mapped = (paddr == REG_STATUS) || (paddr == REG_CTRL) ||
             (paddr == REG_PC) || (paddr == REG_SP);
    if (psel && !penable) begin
      case (paddr)
        REG_STATUS: s_d.prdata = {24'h000000, s_q.flags};
        REG_CTRL: s_d.prdata = {31'h00000000, s_q.run};
        REG_PC: s_d.prdata = {16'h0000, s_q.pc};
        REG_SP: s_d.prdata = {16'h0000, s_q.sp};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    if (apb_wr && paddr == REG_CTRL) begin
      s_d.run = pwdata[0];
    end
    // core state only writable while halted, so no race with execution
    if (apb_wr && !s_q.run && s_q.ph == PH_RUN) begin
      if (paddr == REG_PC) begin
        s_d.pc = pwdata[15:0];
        s_d.v = 1'b0;
      end
      if (paddr == REG_STATUS) begin
        f = pwdata[7:0];
      end
    end
    s_d.flags = {f[7:5], f[FLAG_N] ^ f[FLAG_V], f[3:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.sp <= SP_INIT;
      s_q.run <= RUN_RESET;
      s_q.flags <= FLAGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign pm_addr = s_q.pc;
  assign pm_wr = s_q.pmw;
  assign dm_req = s_q.dm;
  assign irq_ack = s_q.ack;
  assign irq_ack_id = s_q.ack_id;
endmodule // csf_core

// [sim/csf_core_props.sv]
// csf_core_props: port-level assertions for the core datapath
module csf_core_props import csf_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memories
  input wire logic [15:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire csf_pmw_t pm_wr,
  input wire csf_dm_t dm_req,
  input wire logic [7:0] dm_rdata,
  // interrupts
  input wire logic [IRQ_N-1:0] irq,
  input wire logic irq_ack,
  input wire logic [IRQ_IDW-1:0] irq_ack_id
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [IRQ_N-1:0] irq_q;
  logic acc;
  logic bad;
  assign acc = dm_req.we | dm_req.re;
  assign bad = !(paddr inside {REG_STATUS, REG_CTRL, REG_PC, REG_SP});
  // ack is decided on the previous cycle's requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= '0;
    end else begin
      irq_q <= irq;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence push_lo;
    dm_req.we;
  endsequence
  sequence push_hi;
    dm_req.we && dm_req.addr == $past(dm_req.addr) - 16'h0001;
  endsequence
  chk_ack_cause:
    assert property (irq_ack |-> irq_q[irq_ack_id])
    else $error("ack without a pending request");
  chk_lowest_wins:
    assert property (irq_ack |->
      (irq_q & ~({IRQ_N{1'b1}} << irq_ack_id)) == '0)
    else $error("lower pending request was passed over");
  chk_push_pair:
    assert property (irq_ack |-> push_lo ##1 push_hi)
    else $error("return address not pushed as two bytes");
  chk_ack_gap:
    assert property (irq_ack |=> !irq_ack [*3])
    else $error("interrupt retaken while enable cleared");
  chk_io_window:
    assert property (acc |->
      dm_req.io == (dm_req.addr inside {[IO_BASE:IO_LAST]}))
    else $error("io window flag wrong");
  chk_ext_window:
    assert property (acc |->
      dm_req.ext == (dm_req.addr inside {[EXT_FIRST:EXT_LAST]}))
    else $error("extended window flag wrong");
  chk_rf_local:
    assert property (acc |-> dm_req.addr >= IO_BASE)
    else $error("register file address went to the bus");
  chk_ack_id_hold:
    assert property (!irq_ack |-> $stable(irq_ack_id))
    else $error("ack index moved without an ack");
  chk_err_unmapped:
    assert property (psel && penable && bad |-> pslverr && pready)
    else $error("unmapped access not flagged");
  chk_refused_zero:
    assert property (psel && penable && !pwrite && bad |-> prdata == '0)
    else $error("unmapped read not zero");
endmodule // csf_core_props

bind csf_core csf_core_props csf_core_props_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pm_addr,
  .pm_rdata, .pm_wr, .dm_req, .dm_rdata, .irq, .irq_ack, .irq_ack_id);

// [sim/csf_mem_model.sv]
// csf_mem_model: program and data memory beside the core
module csf_mem_model import csf_pkg::*; (
  // clock
  input wire logic pclk,
  // program memory
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire csf_pmw_t pm_wr,
  // data memory
  input wire csf_dm_t dm_req,
  output logic [7:0] dm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  // empty words spin in place so a stray fetch cannot run away
  initial begin
    for (int i = 0; i < 65536; i++) begin
      pm[i] = 16'h8FFF;
      dm[i] = 8'h00;
    end
    pm_rdata = 16'h8FFF;
    dm_rdata = 8'h00;
  end
  always @(posedge pclk) begin
    pm_rdata <= pm[pm_addr];
    if (pm_wr.we === 1'b1) pm[pm_wr.addr] <= pm_wr.wdata;
  end
  // stack bytes kept; read data only valid for one cycle
  always @(posedge pclk) begin
    if (dm_req.we === 1'b1) dm[dm_req.addr] <= dm_req.wdata;
    if (dm_req.re === 1'b1) dm_rdata <= dm[dm_req.addr];
    else dm_rdata <= ~dm_rdata;
  end
endmodule // csf_mem_model

// [sim/testbench.sv]
// testbench: directed scenarios for the core datapath
module testbench import csf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SP_I = 16'h21FF;
  localparam logic [15:0] BOOT_I = 16'h0200;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_ack, err;
  logic [7:0] paddr, dm_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pm_addr, pm_rdata, pmw_addr;
  csf_pmw_t pm_wr;
  csf_dm_t dm_req;
  logic [IRQ_N-1:0] irq;
  logic [IRQ_IDW-1:0] irq_ack_id, last_id;
  logic [15:0] wq[$];
  int mismatches, n_checks, cyc, n_ack, n_pmw;

  csf_core #(.SP_INIT(SP_I), .BOOT_START(BOOT_I), .VEC_BASE(16'h0002),
    .VEC_STRIDE(16'h0002)) csf_core_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pm_addr,
    .pm_rdata, .pm_wr, .dm_req, .dm_rdata, .irq, .irq_ack, .irq_ack_id);
  csf_mem_model csf_mem_model_i (.pclk, .pm_addr, .pm_rdata, .pm_wr,
    .dm_req, .dm_rdata);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // every request line drops once any request is acknowledged
  always @(posedge pclk) begin
    cyc++;
    if (irq_ack === 1'b1) begin
      n_ack++;
      last_id = irq_ack_id;
      irq <= '0;
    end
    if (pm_wr.we === 1'b1) begin
      n_pmw++;
      pmw_addr = pm_wr.addr;
    end
    if (dm_req.we === 1'b1) wq.push_back(dm_req.addr);
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sts(input logic [7:0] exp);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", rd, {24'h0, exp});
  endtask

  // flag and pc writes are only taken while halted and settled
  task automatic run(input logic [15:0] base, input logic [15:0] w[$],
    input logic [7:0] pre);
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    apb(1'b1, REG_STATUS, {24'h0, pre});
    foreach (w[i]) csf_mem_model_i.pm[base + 16'(i)] = w[i];
    csf_mem_model_i.pm[base + 16'(w.size())] = 16'h8FFF;
    apb(1'b1, REG_PC, {16'h0, base});
    apb(1'b1, REG_CTRL, 32'h1);
    repeat (40) @(posedge pclk);
  endtask

  task automatic t_reset();
    sts(FLAGS_RESET);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    apb(1'b1, REG_SP, 32'h1234);
    apb(1'b0, REG_SP, 32'h0);
    chk("sp", rd, {16'h0, SP_I});
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk("unmapped wr", 32'(err), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped rd", {rd[31:1], err}, 32'h1);
  endtask

  task automatic t_sflag();
    logic [7:0] tw[3] = '{8'h08, 8'h04, 8'h0C};
    logic [7:0] te[3] = '{8'h18, 8'h14, 8'h0C};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_CTRL, 32'h0);
      apb(1'b1, REG_STATUS, {24'h0, tw[i]});
      sts(te[i]);
    end
  endtask

  task automatic t_alu();
    run(16'h0100, '{16'h307F, 16'h3101, 16'h1844}, 8'h00);
    sts(8'h2C);
    run(16'h0100, '{16'h3010, 16'h4020}, 8'h40);
    sts(8'h55);
    run(16'h0100, '{16'h3F80, 16'h4F80}, 8'h40);
    sts(8'h42);
    run(16'h0100, '{16'h30F0, 16'h310F, 16'h2844}, 8'h21);
    sts(8'h23);
    run(16'h0100, '{16'h3004, 16'h5802, 16'h3100, 16'h588F, 16'h4180}, 8'h00);
    sts(8'h42);
  endtask

  task automatic t_gie();
    run(16'h0100, '{16'h0001}, 8'h00);
    sts(8'h80);
    run(16'h0100, '{16'h0002}, 8'h80);
    sts(8'h00);
  endtask

  task automatic t_irq();
    csf_mem_model_i.pm[16'h0006] = 16'h3000;
    csf_mem_model_i.pm[16'h0007] = 16'h4001;
    csf_mem_model_i.pm[16'h0008] = 16'h0003;
    irq <= 8'h24;
    run(16'h0100, '{16'h3000}, 8'h40);
    chk("gated", 32'(n_ack), 32'h0);
    wq.delete();
    run(16'h0100, '{16'h3000, 16'h3000, 16'h0001}, 8'h40);
    chk("acks", 32'(n_ack), 32'h1);
    chk("ack id", 32'(last_id), 32'h2);
    chk("pushes", 32'(wq.size()), 32'h2);
    chk("push lo", 32'(wq[0]), {16'h0, SP_I});
    chk("push hi", 32'(wq[1]), {16'h0, SP_I - 16'h1});
    sts(8'hF5);
    apb(1'b0, REG_SP, 32'h0);
    chk("sp back", rd, {16'h0, SP_I});
  endtask

  // word after the jump would spoil the result if it ran
  task automatic t_flow();
    wq.delete();
    run(16'h0100, '{16'h30AA, 16'hB000, 16'h0104, 16'h4001, 16'h9002,
      16'h7841, 16'h8FFF, 16'h4001, 16'h0004}, 8'h00);
    chk("call out", 32'(csf_mem_model_i.dm[16'h0021]), 32'hA9);
    chk("ret lo", 32'(csf_mem_model_i.dm[SP_I]), 32'h05);
    chk("ret hi", 32'(csf_mem_model_i.dm[SP_I - 16'h1]), 32'h01);
    chk("flow writes", 32'(wq.size()), 32'h3);
    sts(8'h14);
    apb(1'b0, REG_SP, 32'h0);
    chk("flow sp", rd, {16'h0, SP_I});
  endtask

  // value travels memory, register file, branch, i/o and table read
  task automatic t_ptr();
    csf_mem_model_i.dm[16'h0023] = 8'h5A;
    run(16'h0100, '{16'h303C, 16'h3A60, 16'h3B01, 16'h6804, 16'h6880,
      16'h3C05, 16'h3D00, 16'h6885, 16'h6901, 16'hD900, 16'hA501,
      16'hD900, 16'h7942, 16'h7983, 16'h3E01, 16'h3F02, 16'hCA00,
      16'h79C4, 16'h7A45}, 8'h00);
    chk("ext st", 32'(csf_mem_model_i.dm[16'h0160]), 32'h3C);
    chk("rf via ptr", 32'(csf_mem_model_i.dm[16'h0022]), 32'hC3);
    chk("io in", 32'(csf_mem_model_i.dm[16'h0024]), 32'h5A);
    chk("table", 32'(csf_mem_model_i.dm[16'h0025]), 32'h30);
    sts(8'h15);
  endtask

  task automatic t_bus();
    wq.delete();
    n_pmw = 0;
    run(16'h0100, '{16'h707F, 16'hC001}, 8'h00);
    chk("io wr", 32'(wq.size()), 32'h1);
    chk("io addr", 32'(wq[0]), 32'h5F);
    chk("no pm wr", 32'(n_pmw), 32'h0);
    run(BOOT_I, '{16'h3E10, 16'h3F00, 16'hC001}, 8'h00);
    chk("pm wr", 32'(n_pmw), 32'h1);
    chk("pm wr addr", 32'(pmw_addr), 32'h8);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    irq = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sflag();
    t_alu();
    t_gie();
    t_irq();
    t_flow();
    t_ptr();
    t_bus();
    close_out();
  end
endmodule // testbench
